// ---- logic/stats_timing_pkg.sv ----
// Notes on behaviour
// - Count pixels rejected by chroma key, 24 bits
// - Counters zero at reset and no-op bit0
// - Count pixels rejected by depth test
// - Count pixels rejected by alpha test
// - Alpha masking rejects also count as alpha
// - Count pixels stored to colour buffer
// - RGB write mask ignored for written count
// - Count every pixel walked by triangle engine
// - Swap completion shifts history up four bits
// - New nibble: vsyncs since last swap, saturating
// - Eight nibbles, newest lowest, oldest highest
// - Vertical position readback is read-only counter
// - Vertical readback zero while vsync active
// - Combined readback: vertical low, horizontal high
// - Hsync active below sync-on, display above
// - Synced combined readback handshakes with video unit
// - Hsync register: on 8:0, off 26:16
// - Vsync register: on 12:0, off 28:16
// - Porch register: horizontal 8:0, vertical 24:16
// - Dimensions: width 10:0, height 26:16
// - Horizontal border extents 8:0 and 24:16
// - Vertical border extents 8:0 and 24:16
// - Border colour blue, green, red bytes
// - Filter deltas blue, green, red bytes
package stats_timing_pkg;

    // --------------------------------------------------------------
    // Register indices (word offsets of this bank)
    // --------------------------------------------------------------
    localparam logic [4:0] REG_PIXELS_IN   = 5'h00;
    localparam logic [4:0] REG_CHROMA      = 5'h01;
    localparam logic [4:0] REG_DEPTH       = 5'h02;
    localparam logic [4:0] REG_ALPHA       = 5'h03;
    localparam logic [4:0] REG_PIXELS_OUT  = 5'h04;
    localparam logic [4:0] REG_SWAP_HIST   = 5'h05;
    localparam logic [4:0] REG_VBEAM       = 5'h06;
    localparam logic [4:0] REG_HVBEAM      = 5'h07;
    localparam logic [4:0] REG_HSYNC       = 5'h08;
    localparam logic [4:0] REG_VSYNC       = 5'h09;
    localparam logic [4:0] REG_PORCH       = 5'h0a;
    localparam logic [4:0] REG_DIMS        = 5'h0b;
    localparam logic [4:0] REG_DELTA       = 5'h0c;
    localparam logic [4:0] REG_HORIZ_EDGE_TIMING     = 5'h0d;
    localparam logic [4:0] REG_VERT_EDGE_TIMING     = 5'h0e;
    localparam logic [4:0] REG_BORDER_COL  = 5'h0f;

    // --------------------------------------------------------------
    // Field masks and positions
    // --------------------------------------------------------------
    localparam int          CNT_W          = 24;
    localparam int          HIST_NIB       = 4;
    localparam logic [3:0]  HIST_SAT       = 4'hf;
    localparam logic [31:0] MASK_HSYNC     = 32'h07ff_01ff;
    localparam logic [31:0] MASK_VSYNC     = 32'h1fff_1fff;
    localparam logic [31:0] MASK_PORCH     = 32'h01ff_01ff;
    localparam logic [31:0] MASK_DIMS      = 32'h07ff_07ff;
    localparam logic [31:0] MASK_RGB       = 32'h00ff_ffff;
    localparam int          NOP_CLR_BIT    = 0;
    localparam int          HBEAM_LSB      = 16;
    localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
    localparam int          VCNT_W         = 13;
    localparam int          HCNT_W         = 11;

    // --------------------------------------------------------------
    // Carriers
    // --------------------------------------------------------------
    typedef struct packed {
        logic walked;      // triangle engine visited a pixel
        logic chroma_fail;
        logic depth_fail;
        logic alpha_fail;
        logic amask_fail;  // alpha masking test reject
        logic stored;      // pixel stored, write mask not considered
    } pixel_events_s;

    typedef struct packed {
        logic [VCNT_W-1:0] vcount;
        logic [HCNT_W-1:0] hcount;
        logic              vsync_active;
    } beam_s;

    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_REQ  = 3'b010,
        RD_DONE = 3'b100
    } read_state_e;

endpackage

// ---- logic/render_stats_video_timing_regs.sv ----
`timescale 1ns/10ps
module render_stats_video_timing_regs #(
    parameter int COUNTER_WIDTH = 24
) (
    input  wire logic                              mclk,
    input  wire logic                              rst,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    input  wire logic [4:0]                        reg_index,
    input  wire logic [31:0]                       reg_wdata,
    output logic [31:0]                            reg_rdata,
    output logic                                   reg_rvalid,
    input  wire logic                              nop_cmd_wr,
    input  wire logic [31:0]                       nop_cmd_data,
    input  wire stats_timing_pkg::pixel_events_s   pix,
    input  wire logic                              swap_done,
    input  wire logic                              vsync_pulse,
    input  wire stats_timing_pkg::beam_s           beam,
    input  wire logic                              sync_reads,
    output logic                                   beam_req,
    input  wire logic                              beam_ack,
    output logic                                   hsync_active,
    output logic [31:0]                            horiz_sync_timing,
    output logic [31:0]                            vert_sync_timing,
    output logic [31:0]                            porch_timing,
    output logic [31:0]                            active_display_size,
    output logic [31:0]                            video_filter_max_delta,
    output logic [31:0]                            horiz_edge_timing,
    output logic [31:0]                            vert_edge_timing,
    output logic [31:0]                            edge_fill_colour
);

    // Counter fields are laid out at 24 bits; any other width is refused
    if (COUNTER_WIDTH != stats_timing_pkg::CNT_W) begin : g_width_check
        $error("COUNTER_WIDTH must be 24");
    end

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic [23:0]                   pixels_processed_count;
        logic [23:0]                   chroma_reject_count;
        logic [23:0]                   depth_reject_count;
        logic [23:0]                   alpha_reject_count;
        logic [23:0]                   pixels_written_count;
        logic [31:0]                   swap_vsync_history;
        logic [3:0]                    vsync_since_swap;
        logic [31:0]                   hsync_reg;
        logic [31:0]                   vsync_reg;
        logic [31:0]                   porch_reg;
        logic [31:0]                   dims_reg;
        logic [31:0]                   delta_reg;
        logic [31:0]                   horiz_edge_timing_reg;
        logic [31:0]                   vert_edge_timing_reg;
        logic [31:0]                   border_col_reg;
        stats_timing_pkg::read_state_e rd_state;
        logic [4:0]                    rd_index;
        logic [31:0]                   rdata;
        logic                          rvalid;
        logic                          beam_req;
        logic                          hsync_active;
    } state_s;

    state_s st;
    state_s next_st;

    function automatic logic [23:0] bump(input logic [23:0] c, input logic hit,
                                         input logic clr);
        if (clr)
            return 24'h00_0000;
        return hit ? c + 24'h00_0001 : c;
    endfunction

    function automatic logic [31:0] read_word(input state_s s, input logic [4:0] idx,
                                              input stats_timing_pkg::beam_s b);
        logic [12:0] v;
        v = b.vsync_active ? 13'h0000 : b.vcount;
        case (idx)
            stats_timing_pkg::REG_PIXELS_IN:  return {8'h00, s.pixels_processed_count};
            stats_timing_pkg::REG_CHROMA:     return {8'h00, s.chroma_reject_count};
            stats_timing_pkg::REG_DEPTH:      return {8'h00, s.depth_reject_count};
            stats_timing_pkg::REG_ALPHA:      return {8'h00, s.alpha_reject_count};
            stats_timing_pkg::REG_PIXELS_OUT: return {8'h00, s.pixels_written_count};
            stats_timing_pkg::REG_SWAP_HIST:  return s.swap_vsync_history;
            stats_timing_pkg::REG_VBEAM:      return {19'h0_0000, v};
            stats_timing_pkg::REG_HVBEAM:     return {5'h00, b.hcount, 3'h0, v};
            stats_timing_pkg::REG_HSYNC:      return s.hsync_reg;
            stats_timing_pkg::REG_VSYNC:      return s.vsync_reg;
            stats_timing_pkg::REG_PORCH:      return s.porch_reg;
            stats_timing_pkg::REG_DIMS:       return s.dims_reg;
            stats_timing_pkg::REG_DELTA:      return s.delta_reg;
            stats_timing_pkg::REG_HORIZ_EDGE_TIMING:    return s.horiz_edge_timing_reg;
            stats_timing_pkg::REG_VERT_EDGE_TIMING:    return s.vert_edge_timing_reg;
            stats_timing_pkg::REG_BORDER_COL: return s.border_col_reg;
            default:                          return stats_timing_pkg::RESET_WORD;
        endcase
    endfunction

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        logic clr;
        logic wr_ok;
        clr = nop_cmd_wr && nop_cmd_data[stats_timing_pkg::NOP_CLR_BIT];
        wr_ok = reg_wr;
        next_st = st;

        next_st.pixels_processed_count = bump(st.pixels_processed_count, pix.walked, clr);
        next_st.chroma_reject_count = bump(st.chroma_reject_count, pix.chroma_fail, clr);
        next_st.depth_reject_count  = bump(st.depth_reject_count, pix.depth_fail, clr);
        next_st.alpha_reject_count  = bump(st.alpha_reject_count,
                                           pix.alpha_fail | pix.amask_fail, clr);
        // Write mask is deliberately not an input here
        next_st.pixels_written_count = bump(st.pixels_written_count, pix.stored, clr);

        // A vsync in the swap cycle belongs to the interval just closed
        if (swap_done) begin
            next_st.swap_vsync_history = {st.swap_vsync_history[27:0],
                (vsync_pulse && st.vsync_since_swap != stats_timing_pkg::HIST_SAT)
                    ? st.vsync_since_swap + 4'h1 : st.vsync_since_swap};
            next_st.vsync_since_swap = 4'h0;
        end else if (vsync_pulse && st.vsync_since_swap != stats_timing_pkg::HIST_SAT) begin
            next_st.vsync_since_swap = st.vsync_since_swap + 4'h1;
        end

        if (wr_ok) begin
            case (reg_index)
                stats_timing_pkg::REG_HSYNC:
                    next_st.hsync_reg = reg_wdata & stats_timing_pkg::MASK_HSYNC;
                stats_timing_pkg::REG_VSYNC:
                    next_st.vsync_reg = reg_wdata & stats_timing_pkg::MASK_VSYNC;
                stats_timing_pkg::REG_PORCH:
                    next_st.porch_reg = reg_wdata & stats_timing_pkg::MASK_PORCH;
                stats_timing_pkg::REG_DIMS:
                    next_st.dims_reg = reg_wdata & stats_timing_pkg::MASK_DIMS;
                stats_timing_pkg::REG_DELTA:
                    next_st.delta_reg = reg_wdata & stats_timing_pkg::MASK_RGB;
                stats_timing_pkg::REG_HORIZ_EDGE_TIMING:
                    next_st.horiz_edge_timing_reg = reg_wdata & stats_timing_pkg::MASK_PORCH;
                stats_timing_pkg::REG_VERT_EDGE_TIMING:
                    next_st.vert_edge_timing_reg = reg_wdata & stats_timing_pkg::MASK_PORCH;
                stats_timing_pkg::REG_BORDER_COL:
                    next_st.border_col_reg = reg_wdata & stats_timing_pkg::MASK_RGB;
                default: ;
            endcase
        end

        // Read path: combined beam reads may wait on the video unit
        next_st.rvalid = 1'b0;
        case (st.rd_state)
            stats_timing_pkg::RD_IDLE: begin
                if (reg_rd) begin
                    next_st.rd_index = reg_index;
                    if (sync_reads && (reg_index == stats_timing_pkg::REG_HVBEAM)) begin
                        next_st.beam_req = 1'b1;
                        next_st.rd_state = stats_timing_pkg::RD_REQ;
                    end else begin
                        next_st.rdata = read_word(st, reg_index, beam);
                        next_st.rvalid = 1'b1;
                    end
                end
            end
            stats_timing_pkg::RD_REQ: begin
                if (beam_ack) begin
                    next_st.rdata = read_word(st, st.rd_index, beam);
                    next_st.rvalid = 1'b1;
                    next_st.beam_req = 1'b0;
                    next_st.rd_state = stats_timing_pkg::RD_DONE;
                end
            end
            stats_timing_pkg::RD_DONE: begin
                // Wait for the video unit to drop its acknowledge
                if (!beam_ack)
                    next_st.rd_state = stats_timing_pkg::RD_IDLE;
            end
            default: next_st.rd_state = stats_timing_pkg::RD_IDLE;
        endcase

        next_st.hsync_active = ({5'h00, beam.hcount} < {2'h0, st.hsync_reg[8:0]});
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st          <= '0;
            st.rd_state <= stats_timing_pkg::RD_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // --------------------------------------------------------------
    // Outputs straight from state
    // --------------------------------------------------------------
    assign reg_rdata              = st.rdata;
    assign reg_rvalid             = st.rvalid;
    assign beam_req               = st.beam_req;
    assign hsync_active           = st.hsync_active;
    assign horiz_sync_timing      = st.hsync_reg;
    assign vert_sync_timing       = st.vsync_reg;
    assign porch_timing           = st.porch_reg;
    assign active_display_size    = st.dims_reg;
    assign video_filter_max_delta = st.delta_reg;
    assign horiz_edge_timing      = st.horiz_edge_timing_reg;
    assign vert_edge_timing       = st.vert_edge_timing_reg;
    assign edge_fill_colour       = st.border_col_reg;

endmodule

// ---- verification/stats_regs_chk.sv ----
`timescale 1ns/10ps
module stats_regs_chk (
    input wire logic                    mclk,
    input wire logic                    rst,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [4:0]              reg_index,
    input wire logic [31:0]             reg_wdata,
    input wire logic [31:0]             reg_rdata,
    input wire logic                    reg_rvalid,
    input wire stats_timing_pkg::beam_s beam,
    input wire logic                    sync_reads,
    input wire logic                    beam_req,
    input wire logic                    beam_ack,
    input wire logic                    hsync_active,
    input wire logic [31:0]             horiz_sync_timing,
    input wire logic [31:0]             vert_sync_timing,
    input wire logic [31:0]             edge_fill_colour
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // Read sequences
    // ----------------------------------------------------------------
    // A falling request marks a handshake answer, whose index is long gone
    // A read while the acknowledge is still dropping is refused by design
    sequence plain_ans;
        reg_rvalid && !$fell(beam_req);
    endsequence
    sequence plain_rd;
        reg_rd && !beam_req && !$past(beam_req) && !beam_ack && !$past(beam_ack)
            && !(reg_index == stats_timing_pkg::REG_HVBEAM && sync_reads);
    endsequence
    sequence hs_rd;
        reg_rd && reg_index == stats_timing_pkg::REG_HVBEAM && sync_reads
            && !beam_req && !$past(beam_req) && !beam_ack && !$past(beam_ack);
    endsequence
    sequence ack_seen;
        beam_req && beam_ack;
    endsequence
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    rd_answer_a: assert property (plain_rd |=> reg_rvalid)
        else $error("plain read not answered");
    hs_start_a: assert property (hs_rd |=> beam_req)
        else $error("synced read raised no request");
    hs_finish_a: assert property (ack_seen |-> ##[1:2] (reg_rvalid && !beam_req))
        else $error("acknowledged read not completed");
    cnt_top_zero_a: assert property (plain_ans ##0 ($past(reg_index) < 5'h05)
        |-> reg_rdata[31:24] == 8'h00)
        else $error("counter upper byte not zero");
    vbeam_zero_a: assert property (plain_ans ##0 ($past(reg_index) ==
        stats_timing_pkg::REG_VBEAM && $past(beam.vsync_active)) |-> reg_rdata == 32'h0)
        else $error("vertical readback not zero in sync");
    vbeam_live_a: assert property (plain_ans ##0 ($past(reg_index) ==
        stats_timing_pkg::REG_VBEAM && !$past(beam.vsync_active))
        |-> reg_rdata == {19'h0_0000, $past(beam.vcount)})
        else $error("vertical readback wrong");
    hsync_cfg_a: assert property (reg_wr && reg_index == stats_timing_pkg::REG_HSYNC
        |=> horiz_sync_timing == ($past(reg_wdata) & stats_timing_pkg::MASK_HSYNC))
        else $error("horizontal sync word wrong");
    vsync_cfg_a: assert property (reg_wr && reg_index == stats_timing_pkg::REG_VSYNC
        |=> vert_sync_timing == ($past(reg_wdata) & stats_timing_pkg::MASK_VSYNC))
        else $error("vertical sync word wrong");
    colour_cfg_a: assert property (reg_wr && reg_index == stats_timing_pkg::REG_BORDER_COL
        |=> edge_fill_colour == ($past(reg_wdata) & stats_timing_pkg::MASK_RGB))
        else $error("edge colour wrong");
    hsync_cmp_a: assert property (hsync_active ==
        ($past(beam.hcount) < $past(horiz_sync_timing[8:0])))
        else $error("horizontal sync flag wrong");
endmodule

// ---- verification/tb_render_stats_video_timing_regs.sv ----
`timescale 1ns/10ps
module tb_render_stats_video_timing_regs;
    // The design serves only the documented counter width
    localparam int CW = stats_timing_pkg::CNT_W;
    localparam logic [31:0] MASKS [8] = '{stats_timing_pkg::MASK_HSYNC,
        stats_timing_pkg::MASK_VSYNC, stats_timing_pkg::MASK_PORCH, stats_timing_pkg::MASK_DIMS,
        stats_timing_pkg::MASK_RGB, stats_timing_pkg::MASK_PORCH, stats_timing_pkg::MASK_PORCH,
        stats_timing_pkg::MASK_RGB};
    logic                            mclk, rst, reg_wr, reg_rd, nop_cmd_wr, swap_done;
    logic                            vsync_pulse, sync_reads, beam_ack, beam_req, reg_rvalid;
    logic                            hsync_active;
    logic [4:0]                      reg_index;
    logic [31:0]                     reg_wdata, nop_cmd_data, reg_rdata, seed, hist, v;
    logic [31:0]                     cfg_out [8];
    logic [31:0]                     q [$];
    stats_timing_pkg::pixel_events_s pix;
    stats_timing_pkg::beam_s         beam;
    int                              num_errors, checked, cnt [5];

    render_stats_video_timing_regs #(.COUNTER_WIDTH(CW)) i_render_stats_video_timing_regs (
        .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_index(reg_index),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .nop_cmd_wr(nop_cmd_wr), .nop_cmd_data(nop_cmd_data), .pix(pix), .swap_done(swap_done),
        .vsync_pulse(vsync_pulse), .beam(beam), .sync_reads(sync_reads), .beam_req(beam_req),
        .beam_ack(beam_ack), .hsync_active(hsync_active), .horiz_sync_timing(cfg_out[0]),
        .vert_sync_timing(cfg_out[1]), .porch_timing(cfg_out[2]),
        .active_display_size(cfg_out[3]), .video_filter_max_delta(cfg_out[4]),
        .horiz_edge_timing(cfg_out[5]), .vert_edge_timing(cfg_out[6]),
        .edge_fill_colour(cfg_out[7]));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr(input logic [4:0] i, input logic [31:0] d);
        @(negedge mclk);
        reg_wr    = 1'b1;
        reg_index = i;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [4:0] i, input logic [31:0] e);
        @(negedge mclk);
        reg_rd    = 1'b1;
        reg_index = i;
        q.push_back(e);
        @(negedge mclk);
        reg_rd = 1'b0;
    endtask
    task automatic rd_counts();
        for (int k = 0; k < 5; k++) begin
            rd(5'(k), 32'(cnt[k] % (1 << CW)));
        end
    endtask
    task automatic nop(input logic [31:0] d);
        @(negedge mclk);
        nop_cmd_wr   = 1'b1;
        nop_cmd_data = d;
        pix          = '1;
        foreach (cnt[k]) cnt[k] = d[0] ? 0 : cnt[k] + 1;
        @(negedge mclk);
        nop_cmd_wr = 1'b0;
        pix        = '0;
    endtask
    task automatic swap(input int n, input logic same);
        repeat (n) begin
            @(negedge mclk);
            vsync_pulse = 1'b1;
            @(negedge mclk);
            vsync_pulse = 1'b0;
        end
        @(negedge mclk);
        swap_done   = 1'b1;
        vsync_pulse = same;
        @(negedge mclk);
        swap_done   = 1'b0;
        vsync_pulse = 1'b0;
        n = n + same;
        hist = {hist[27:0], (n > 15) ? 4'hf : 4'(n)};
    endtask
    task automatic wait_req(input logic lvl);
        for (int t = 0; t < 20 && beam_req !== lvl; t++) @(negedge mclk);
        if (beam_req !== lvl) begin
            num_errors++;
            $display("ERROR %0t handshake request stuck", $time);
        end
    endtask
    task automatic done(input string name);
        repeat (3) @(negedge mclk);
        if (q.size() != 0) begin
            num_errors++;
            $display("ERROR %0t %0d answers missing", $time, q.size());
            q.delete();
        end
        $display("test %s finished", name);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Answer monitor
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (reg_rvalid === 1'b1) begin
            checked++;
            if (q.size() == 0 || reg_rdata !== q[0]) begin
                num_errors++;
                $display("ERROR %0t unexpected read data %h", $time, reg_rdata);
            end
            if (q.size() != 0) void'(q.pop_front());
        end
    end

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        repeat (10000) @(posedge mclk);
        num_errors++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst, reg_wr, reg_rd, nop_cmd_wr, swap_done, vsync_pulse, sync_reads, beam_ack} = 8'h80;
        {reg_index, reg_wdata, nop_cmd_data, pix, beam, hist} = '0;
        seed = 32'h0001_68a3;
        num_errors = 0;
        checked = 0;
        foreach (cnt[k]) cnt[k] = 0;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        for (int k = 0; k < 16; k++) rd(5'(k), 32'h0000_0000);
        rd(5'h1f, 32'h0000_0000);
        done("reset");
        for (int c = 0; c < 600; c++) begin
            @(negedge mclk);
            seed = lfsr(seed);
            pix  = stats_timing_pkg::pixel_events_s'(seed[5:0]);
            cnt[0] += pix.walked;
            cnt[1] += pix.chroma_fail;
            cnt[2] += pix.depth_fail;
            cnt[3] += pix.alpha_fail | pix.amask_fail;
            cnt[4] += pix.stored;
        end
        @(negedge mclk);
        pix = '0;
        rd_counts();
        wr(stats_timing_pkg::REG_CHROMA, 32'h0000_00aa);
        wr(5'h1f, 32'hffff_ffff);
        rd(5'h1f, 32'h0000_0000);
        nop(32'hffff_fffe);
        rd_counts();
        nop(32'h0000_0001);
        rd_counts();
        done("counters");
        swap(17, 1'b1);
        for (int s = 0; s < 10; s++) begin
            seed = lfsr(seed);
            swap(seed % 18, seed[8]);
            rd(stats_timing_pkg::REG_SWAP_HIST, hist);
        end
        done("history");
        for (int k = 8; k < 16; k++) begin
            seed = lfsr(seed);
            wr(5'(k), seed);
            checked++;
            if (cfg_out[k-8] !== (seed & MASKS[k-8])) begin
                num_errors++;
                $display("ERROR %0t config output %0d wrong", $time, k);
            end
            rd(5'(k), seed & MASKS[k-8]);
        end
        done("config");
        for (int b = 0; b < 12; b++) begin
            seed = lfsr(seed);
            if (b[0]) wr(stats_timing_pkg::REG_HSYNC, seed);
            sync_reads = b > 7;
            beam = stats_timing_pkg::beam_s'({seed[12:0], seed[26:16], seed[31] && b < 8});
            v = beam.vsync_active ? 32'h0 : {19'h0_0000, beam.vcount};
            if (b < 8) rd(stats_timing_pkg::REG_VBEAM, v);
            rd(stats_timing_pkg::REG_HVBEAM, {5'h00, beam.hcount, 3'h0, v[12:0]});
            if (b > 7) begin
                wait_req(1'b1);
                @(negedge mclk);
                reg_rd    = 1'b1;
                reg_index = stats_timing_pkg::REG_CHROMA;
                @(negedge mclk);
                reg_rd = 1'b0;
                repeat (b % 4) @(negedge mclk);
                beam_ack = 1'b1;
                wait_req(1'b0);
                beam_ack = 1'b0;
                repeat (3) @(negedge mclk);
            end
        end
        done("beam");
        report_and_stop();
    end
endmodule

bind render_stats_video_timing_regs stats_regs_chk i_stats_regs_chk (.mclk(mclk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_index(reg_index), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .beam(beam), .sync_reads(sync_reads),
    .beam_req(beam_req), .beam_ack(beam_ack), .hsync_active(hsync_active),
    .horiz_sync_timing(horiz_sync_timing), .vert_sync_timing(vert_sync_timing),
    .edge_fill_colour(edge_fill_colour));
